// ---- logic/csg_pkg.sv ----
// Shared constants and types of the current-share phase control block.
// Assumes a single 125 MHz system clock and a group of at most eight phases.
`default_nettype none
package csg_pkg;
	// System clock rate in hertz and in kilohertz.
	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned CLK_KHZ         = CLK_HZ / 1000;
	// Sync clock stops this many milliseconds after the enable drops.
	localparam int unsigned SYNC_TO_MS      = 500;
	localparam int unsigned SYNC_TO_CYC     = SYNC_TO_MS * CLK_KHZ;
	// Extra start delay of the reference phase, in milliseconds.
	localparam int unsigned REF_DLY_MS      = 10;
	localparam int unsigned REF_DLY_CYC     = REF_DLY_MS * CLK_KHZ;
	// Width of the long timers; holds the longest count above.
	localparam int unsigned CNT_W           = 27;
	// Minimum pulse is the switching period divided by this figure.
	localparam int unsigned MIN_DUTY_DIV    = 128;
	localparam int unsigned MIN_DUTY_SHIFT  = $clog2(MIN_DUTY_DIV);
	// Group geometry.
	localparam int unsigned MAX_PHASES      = 8;
	localparam int unsigned POS_W           = 4;
	// Data widths.
	localparam int unsigned CUR_W           = 16;
	localparam int unsigned PER_W           = 16;
	localparam int unsigned BLANK_W         = 8;
	// Temperature correction setting layout and reset value.
	localparam int unsigned TC_SRC_BIT      = 7;
	localparam int unsigned TC_COEF_MSB     = 6;
	localparam int unsigned TC_COEF_LSB     = 0;
	localparam logic [7:0]  TC_RESET        = 8'h00;
	// Step of the coefficient field in ppm per degree.
	localparam int unsigned TC_STEP_PPM     = 100;

	// Current sensing schemes.
	typedef enum logic [1:0] {
		CSG_SNS_GND_DOWN = 2'h0,
		CSG_SNS_OUT_DOWN = 2'h1,
		CSG_SNS_OUT_UP   = 2'h2
	} csg_sense_t;

	// Start-up sequence of one phase.
	typedef enum logic [2:0] {
		CSG_ST_IDLE   = 3'h0,
		CSG_ST_INIT   = 3'h1,
		CSG_ST_DELAY  = 3'h2,
		CSG_ST_FROZEN = 3'h3,
		CSG_ST_RUN    = 3'h4
	} csg_state_t;
endpackage
`default_nettype wire

// ---- logic/csg_ref_elect.sv ----
// Picks the alive group member with the lowest position.
// Assumes bit k of the alive map stands for position k+1.
`timescale 1ns/1ps
`default_nettype none
module csg_ref_elect (
	input  wire logic [csg_pkg::MAX_PHASES-1:0] alive_i,
	output logic      [csg_pkg::POS_W-1:0]      ref_pos_o
);
	import csg_pkg::*;

	// Scan from the top down so the lowest alive position wins last.
	always_comb begin
		ref_pos_o = '0;
		for (int k = MAX_PHASES - 1; k >= 0; k--) begin
			if (alive_i[k]) begin
				ref_pos_o = POS_W'(k + 1);
			end
		end
	end
endmodule
`default_nettype wire

// ---- logic/csg_phase_ctrl.sv ----
// Configuration and control of one phase in a current-share group.
// Assumes all inputs synchronous to sys_clk_i; sync pin is split into
// input, output and active-low output enable.
//
// Behaviour
// (R1) Lowest position member becomes reference at start.
// (R2) On reference loss, next lowest takes over.
// (R3) Reference sends its current to all members.
// (R4) Host gives group one shared rail identifier.
// (R5) Group setting: count, position, share enable.
// (R6) Min duty gives pulse of period over 128.
// (R7) Sync source always drives, ignores time-out.
// (R8) Time-out stops sync 500 ms after disable.
// (R9) Pinstrap plus output-internal drives internal clock.
// (R10) Input-only takes external sync, never drives.
// (R11) Monitor standby finishes init before rail enable.
// (R12) Transmit inhibit forbids management bus mastering.
// (R13) Blank current sensing after each switch edge.
// (R14) Sense method picks one of three schemes.
// (R15) Fast transient response during ramp or after good.
// (R16) Sync driver open-drain or push-pull.
// (R17) Bit 7 picks internal or external sensor.
// (R18) Bits 6:0 coefficient, applied as negative correction.
// (R19) Reference trim zero; members trim to balance.
// (R20) Host programs identical setpoint in every phase.
// (R21) Host enables alternate ramp in all phases.
// (R22) Reference ramp event releases frozen members together.
`timescale 1ns/1ps
`default_nettype none
module csg_phase_ctrl #(
	parameter int unsigned SYNC_TO_CYCLES = csg_pkg::SYNC_TO_CYC,
	parameter int unsigned REF_DLY_CYCLES = csg_pkg::REF_DLY_CYC
) (
	input  wire logic                          sys_clk_i,
	input  wire logic                          srst_i,
	// Group setting load.
	input  wire logic                          grp_wr_i,
	input  wire logic [csg_pkg::POS_W-1:0]     grp_count_i,
	input  wire logic [csg_pkg::POS_W-1:0]     grp_pos_i,
	input  wire logic                          grp_share_en_i,
	// Static option settings.
	input  wire logic                          min_duty_en_i,
	input  wire logic                          sync_to_en_i,
	input  wire logic                          sync_pinstrap_i,
	input  wire logic                          sync_pin_out_i,
	input  wire logic                          sync_push_pull_i,
	input  wire logic                          standby_monitor_i,
	input  wire logic                          tx_inhibit_i,
	input  wire logic [csg_pkg::BLANK_W-1:0]   blank_dly_i,
	input  wire logic [1:0]                    sense_method_i,
	input  wire logic                          ftr_wait_pg_i,
	// Temperature correction setting access.
	input  wire logic                          tc_wr_i,
	input  wire logic [7:0]                    tc_wdata_i,
	// Phase state.
	input  wire logic                          enable_i,
	input  wire logic                          fw_init_done_i,
	input  wire logic                          power_good_i,
	input  wire logic                          fault_i,
	input  wire logic [csg_pkg::PER_W-1:0]     sw_period_i,
	input  wire logic                          int_clk_i,
	input  wire logic                          top_edge_i,
	input  wire logic                          bot_edge_i,
	input  wire logic [csg_pkg::CUR_W-1:0]     meas_cur_i,
	// Inter-device event bus, receive side.
	input  wire logic [csg_pkg::MAX_PHASES-1:0] evb_alive_i,
	input  wire logic [csg_pkg::CUR_W-1:0]     evb_cur_i,
	input  wire logic                          evb_ramp_i,
	// Sync pin input.
	input  wire logic                          sync_i,
	// Inter-device event bus, transmit side.
	output logic      [csg_pkg::CUR_W-1:0]     evb_cur_o,
	output logic                               evb_cur_vld_o,
	output logic                               evb_ramp_o,
	// Role and group setting readback.
	output logic                               is_ref_o,
	output logic      [csg_pkg::POS_W-1:0]     grp_count_o,
	output logic      [csg_pkg::POS_W-1:0]     grp_pos_o,
	output logic                               grp_share_en_o,
	// Sync pin drive.
	output logic                               sync_o,
	output logic                               sync_oe_n_o,
	output logic                               sync_run_o,
	output logic                               timing_clk_o,
	// Power stage control.
	output logic                               rail_en_o,
	output logic                               pwm_go_o,
	output logic                               min_duty_act_o,
	output logic      [csg_pkg::PER_W-1:0]     min_pulse_o,
	output logic                               blank_o,
	output logic      [1:0]                    sense_method_o,
	output logic                               ftr_en_o,
	output logic                               bus_master_ok_o,
	// Temperature correction.
	output logic      [7:0]                    tc_rdata_o,
	output logic                               tc_src_ext_o,
	output logic      [7:0]                    tc_corr_o,
	// Output trim steering.
	output logic                               trim_zero_o,
	output logic                               trim_up_o,
	output logic                               trim_dn_o
);
	import csg_pkg::*;

	// Long timer loads, cut to the timer width on purpose.
	localparam logic [CNT_W-1:0] TO_LOAD  = CNT_W'(SYNC_TO_CYCLES);
	localparam logic [CNT_W-1:0] DLY_LOAD = CNT_W'(REF_DLY_CYCLES);

	// Every flip-flop of the block lives in this one struct.
	typedef struct packed {
		csg_state_t              st;
		logic [POS_W-1:0]        count;
		logic [POS_W-1:0]        pos;
		logic                    share_en;
		logic [7:0]              tc;
		logic [CNT_W-1:0]        to_cnt;
		logic [CNT_W-1:0]        dly_cnt;
		logic [BLANK_W-1:0]      blank_cnt;
		logic                    is_ref;
		logic [CUR_W-1:0]        cur_tx;
		logic                    cur_vld;
		logic                    ramp_tx;
		logic                    sync_out;
		logic                    sync_oe_n;
		logic                    sync_run;
		logic                    tclk;
		logic                    rail_en;
		logic                    pwm_go;
		logic                    min_act;
		logic [PER_W-1:0]        min_pulse;
		logic                    blank;
		logic [1:0]              sense;
		logic                    ftr_en;
		logic                    master_ok;
		logic [7:0]              tc_corr;
		logic                    trim_zero;
		logic                    trim_up;
		logic                    trim_dn;
	} csg_regs_t;

	csg_regs_t                   state_reg;    // Registered state.
	csg_regs_t                   state_next;   // Next state.
	logic [MAX_PHASES-1:0]       alive_map;    // Members able to lead.
	logic [POS_W-1:0]            lead_pos;     // Lowest alive position.
	logic [MAX_PHASES-1:0]       self_bit;     // Own slot in the map.

	// Own slot is set only while sharing and free of faults.
	always_comb begin
		self_bit = '0;
		if (state_reg.share_en && !fault_i && state_reg.pos != '0) begin
			self_bit = MAX_PHASES'(1) << (state_reg.pos - POS_W'(1));
		end
		alive_map = evb_alive_i | self_bit;
	end

	// Election is continuous, so a dropped leader is replaced at once.
	csg_ref_elect u_elect (
		.alive_i   (alive_map),
		.ref_pos_o (lead_pos)
	);

	// Next-state logic for the whole phase.
	always_comb begin
		logic src;
		logic lead;
		src = 1'b0;
		lead = 1'b0;
		state_next = state_reg;
		state_next.ramp_tx = 1'b0;
		state_next.pwm_go = 1'b0;

		// Group setting holds count, position and share enable.
		if (grp_wr_i) begin
			state_next.count = grp_count_i;     // see R5
			state_next.pos = grp_pos_i;         // see R5
			state_next.share_en = grp_share_en_i; // see R5
		end

		// Lowest alive position leads, also after a drop or fault.
		lead = state_reg.share_en && (lead_pos == state_reg.pos) && (lead_pos != '0); // see R1 see R2
		state_next.is_ref = lead;

		// The leader publishes its measured current every cycle.
		state_next.cur_tx = lead ? meas_cur_i : '0; // see R3
		state_next.cur_vld = lead;                  // see R3

		// Temperature correction setting write.
		if (tc_wr_i) begin
			state_next.tc = tc_wdata_i;
		end
		state_next.tc_corr = 8'h00 - {1'b0, state_reg.tc[TC_COEF_MSB:TC_COEF_LSB]}; // see R18

		// Sync source mode needs pinstrap input and output of the internal clock.
		src = sync_pinstrap_i && sync_pin_out_i; // see R9
		if (src) begin
			// A source never times out.
			state_next.to_cnt = TO_LOAD;  // see R7
			state_next.sync_run = 1'b1;   // see R7
		end else if (enable_i || !sync_to_en_i) begin
			state_next.to_cnt = TO_LOAD;
			state_next.sync_run = 1'b1;
		end else if (state_reg.to_cnt > CNT_W'(1)) begin
			state_next.to_cnt = state_reg.to_cnt - CNT_W'(1); // see R8
		end else begin
			state_next.to_cnt = '0;
			state_next.sync_run = 1'b0; // see R8
		end

		// Pin drive: push-pull drives both levels, open-drain only pulls low.
		if (src && state_next.sync_run) begin
			if (sync_push_pull_i) begin
				state_next.sync_out = int_clk_i;  // see R16
				state_next.sync_oe_n = 1'b0;      // see R16
			end else begin
				state_next.sync_out = 1'b0;       // see R16
				state_next.sync_oe_n = int_clk_i; // see R16
			end
		end else begin
			// Input-only and stopped pins are released.
			state_next.sync_out = 1'b0;
			state_next.sync_oe_n = 1'b1; // see R10
		end
		// Timing follows the internal clock when output is selected, the pin otherwise.
		state_next.tclk = sync_pin_out_i ? int_clk_i : sync_i; // see R9 see R10

		// Minimum pulse is a shift, exact because the divisor is a power of two.
		state_next.min_act = min_duty_en_i;
		state_next.min_pulse = min_duty_en_i ? (sw_period_i >> MIN_DUTY_SHIFT) : '0; // see R6

		// Blanking restarts on every switch transition.
		if (top_edge_i || bot_edge_i) begin
			state_next.blank_cnt = blank_dly_i; // see R13
		end else if (state_reg.blank_cnt != '0) begin
			state_next.blank_cnt = state_reg.blank_cnt - BLANK_W'(1);
		end
		state_next.blank = (state_next.blank_cnt != '0); // see R13

		// Unknown codes fall back to the ground-referenced scheme.
		case (sense_method_i)
			CSG_SNS_OUT_DOWN: state_next.sense = CSG_SNS_OUT_DOWN; // see R14
			CSG_SNS_OUT_UP:   state_next.sense = CSG_SNS_OUT_UP;   // see R14
			default:          state_next.sense = CSG_SNS_GND_DOWN; // see R14
		endcase

		// Fast response waits for power-good when so selected.
		state_next.ftr_en = state_reg.rail_en && (!ftr_wait_pg_i || power_good_i); // see R15

		// Inhibited phases never master the management bus.
		state_next.master_ok = !tx_inhibit_i; // see R12

		// Trim: leader holds zero, members chase the leader's current.
		state_next.trim_zero = lead || !state_reg.share_en; // see R19
		state_next.trim_up = !lead && state_reg.share_en && (meas_cur_i < evb_cur_i); // see R19
		state_next.trim_dn = !lead && state_reg.share_en && (meas_cur_i > evb_cur_i); // see R19

		// Start-up sequence.
		case (state_reg.st)
			CSG_ST_IDLE: begin
				state_next.rail_en = 1'b0;
				if (enable_i) begin
					state_next.st = CSG_ST_INIT;
				end
			end
			CSG_ST_INIT: begin
				// Monitor mode holds the rail until firmware init is done.
				if (!enable_i) begin
					state_next.st = CSG_ST_IDLE;
				end else if (!standby_monitor_i || fw_init_done_i) begin // see R11
					state_next.dly_cnt = DLY_LOAD;
					state_next.st = lead ? CSG_ST_DELAY : CSG_ST_FROZEN;
				end
			end
			CSG_ST_DELAY: begin
				// Leader waits its extra delay, then fires the ramp event.
				if (!enable_i) begin
					state_next.st = CSG_ST_IDLE;
				end else if (state_reg.dly_cnt > CNT_W'(1)) begin
					state_next.dly_cnt = state_reg.dly_cnt - CNT_W'(1);
				end else begin
					state_next.ramp_tx = 1'b1; // see R22
					state_next.pwm_go = 1'b1;  // see R22
					state_next.rail_en = 1'b1; // see R11
					state_next.st = CSG_ST_RUN;
				end
			end
			CSG_ST_FROZEN: begin
				// Members stay frozen until the ramp event arrives.
				if (!enable_i) begin
					state_next.st = CSG_ST_IDLE;
				end else if (evb_ramp_i || !state_reg.share_en) begin // see R22
					state_next.pwm_go = 1'b1;  // see R22
					state_next.rail_en = 1'b1; // see R11
					state_next.st = CSG_ST_RUN;
				end
			end
			CSG_ST_RUN: begin
				if (!enable_i) begin
					state_next.rail_en = 1'b0;
					state_next.st = CSG_ST_IDLE;
				end
			end
			default: begin
				state_next.rail_en = 1'b0;
				state_next.st = CSG_ST_IDLE;
			end
		endcase
	end

	// Single register stage; synchronous reset to a quiet, released pin.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state_reg <= '0;
			state_reg.st <= CSG_ST_IDLE;
			state_reg.tc <= TC_RESET;
			state_reg.to_cnt <= TO_LOAD;
			state_reg.sync_oe_n <= 1'b1;
			state_reg.sync_run <= 1'b1;
			state_reg.master_ok <= 1'b1;
			state_reg.trim_zero <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from the state flops.
	assign evb_cur_o       = state_reg.cur_tx;
	assign evb_cur_vld_o   = state_reg.cur_vld;
	assign evb_ramp_o      = state_reg.ramp_tx;
	assign is_ref_o        = state_reg.is_ref;
	assign grp_count_o     = state_reg.count;
	assign grp_pos_o       = state_reg.pos;
	assign grp_share_en_o  = state_reg.share_en;
	assign sync_o          = state_reg.sync_out;
	assign sync_oe_n_o     = state_reg.sync_oe_n;
	assign sync_run_o      = state_reg.sync_run;
	assign timing_clk_o    = state_reg.tclk;
	assign rail_en_o       = state_reg.rail_en;
	assign pwm_go_o        = state_reg.pwm_go;
	assign min_duty_act_o  = state_reg.min_act;
	assign min_pulse_o     = state_reg.min_pulse;
	assign blank_o         = state_reg.blank;
	assign sense_method_o  = state_reg.sense;
	assign ftr_en_o        = state_reg.ftr_en;
	assign bus_master_ok_o = state_reg.master_ok;
	assign tc_rdata_o      = state_reg.tc;
	assign tc_src_ext_o    = state_reg.tc[TC_SRC_BIT]; // see R17
	assign tc_corr_o       = state_reg.tc_corr;
	assign trim_zero_o     = state_reg.trim_zero;
	assign trim_up_o       = state_reg.trim_up;
	assign trim_dn_o       = state_reg.trim_dn;
endmodule
`default_nettype wire

// ---- test/csg_phase_ctrl_monitor.sv ----
// Concurrent checks on the ports of one phase control block.
// Assumes one clock sys_clk_i and a synchronous, active high srst_i.
`timescale 1ns/1ps
`default_nettype none
module csg_phase_monitor (
	input wire logic                      sys_clk_i,
	input wire logic                      srst_i,
	input wire logic                      tx_inhibit_i,
	input wire logic                      bus_master_ok_o,
	input wire logic                      sync_pinstrap_i,
	input wire logic                      sync_pin_out_i,
	input wire logic                      sync_push_pull_i,
	input wire logic                      int_clk_i,
	input wire logic                      sync_i,
	input wire logic                      sync_o,
	input wire logic                      sync_oe_n_o,
	input wire logic                      timing_clk_o,
	input wire logic                      min_duty_en_i,
	input wire logic [csg_pkg::PER_W-1:0] sw_period_i,
	input wire logic [csg_pkg::PER_W-1:0] min_pulse_o,
	input wire logic                      tc_wr_i,
	input wire logic [7:0]                tc_rdata_o,
	input wire logic [7:0]                tc_corr_o,
	input wire logic                      is_ref_o,
	input wire logic                      trim_zero_o,
	input wire logic                      trim_up_o,
	input wire logic                      trim_dn_o,
	input wire logic                      evb_ramp_o,
	input wire logic                      pwm_go_o
);
	import csg_pkg::*;
	// Every check runs on the one clock and sleeps through reset.
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	chk_master_withdrawn: assert property (tx_inhibit_i |=> !bus_master_ok_o)
		else $error("bus mastering still allowed under inhibit");
	// Three cycles of settled source setup leave room for the run flag to settle.
	chk_source_drives: assert property ((sync_pinstrap_i && sync_pin_out_i && sync_push_pull_i) [*3]
		|=> !sync_oe_n_o && sync_o == $past(int_clk_i)) else $error("sync source not driving");
	chk_input_floats: assert property (!sync_pin_out_i |=> sync_oe_n_o)
		else $error("input-only phase drives the sync pin");
	chk_ext_timing: assert property (!sync_pin_out_i |=> timing_clk_o == $past(sync_i))
		else $error("timing clock not taken from the sync pin");
	chk_min_pulse: assert property (min_duty_en_i |=> min_pulse_o == ($past(sw_period_i) >> 7))
		else $error("minimum pulse is not period over 128");
	chk_tc_negate: assert property (tc_wr_i |=> ##1 tc_corr_o == 8'h00 - ($past(tc_rdata_o) & 8'h7F))
		else $error("correction is not the negated coefficient");
	chk_ref_trim: assert property (is_ref_o |-> trim_zero_o && !trim_up_o && !trim_dn_o)
		else $error("reference phase trims its output");
	chk_ramp_release: assert property (evb_ramp_o |-> pwm_go_o)
		else $error("ramp event without own pulse start");
	chk_ramp_single: assert property (evb_ramp_o |=> !evb_ramp_o)
		else $error("ramp event longer than one cycle");
endmodule
bind csg_phase_ctrl csg_phase_monitor csg_phase_monitor_inst (.*);
`default_nettype wire

// ---- test/csg_peer_model.sv ----
// Behavioural model of the other phases on the event bus.
// Assumes the bench commands alive map, leader current and ramp events.
`timescale 1ns/1ps
`default_nettype none
module csg_peer_model (
	input  wire logic                           sys_clk_i,
	input  wire logic [csg_pkg::MAX_PHASES-1:0] alive_i,
	input  wire logic [csg_pkg::CUR_W-1:0]      cur_i,
	input  wire logic                           ramp_req_i,
	output logic      [csg_pkg::MAX_PHASES-1:0] evb_alive_o,
	output logic      [csg_pkg::CUR_W-1:0]      evb_cur_o,
	output logic                                evb_ramp_o
);
	import csg_pkg::*;
	// Quiet bus at time zero so the phase never sees an unknown.
	initial begin
		evb_alive_o = '0;
		evb_cur_o   = '0;
		evb_ramp_o  = 1'b0;
	end
	// Peers drop out of the map when faulted or removed.
	always @(posedge sys_clk_i) begin
		evb_alive_o <= alive_i;
		// With no peer alive nobody owns the current, so the value must not linger.
		evb_cur_o   <= (alive_i != '0) ? cur_i : ~evb_cur_o;
		evb_ramp_o  <= ramp_req_i;
	end
endmodule
`default_nettype wire

// ---- test/csg_phase_ctrl_bench.sv ----
// Self-checking bench of one current-share phase control block.
// Assumes the peer model and checker compile before this file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
`define WAITF(c, n) begin for (k = 0; k < (n) && !(c); k++) @(negedge sys_clk_i); \
	if (!(c)) begin err_count++; stop_test(); end end
module csg_phase_ctrl_bench;
	import csg_pkg::*;
	// Short counts keep the run brief.
	localparam int unsigned TO_CYC  = 20;
	localparam int unsigned DLY_CYC = 10;
	logic sys_clk_i, srst_i, grp_wr_i, grp_share_en_i, min_duty_en_i, sync_to_en_i, sync_pinstrap_i;
	logic sync_pin_out_i, sync_push_pull_i, standby_monitor_i, tx_inhibit_i, ftr_wait_pg_i, tc_wr_i;
	logic enable_i, fw_init_done_i, power_good_i, fault_i, int_clk_i, top_edge_i, bot_edge_i, evb_ramp_i;
	logic evb_cur_vld_o, evb_ramp_o, is_ref_o, grp_share_en_o, sync_o, sync_oe_n_o, sync_run_o, timing_clk_o;
	logic rail_en_o, pwm_go_o, min_duty_act_o, blank_o, ftr_en_o, bus_master_ok_o, tc_src_ext_o;
	logic trim_zero_o, trim_up_o, trim_dn_o, sync_i, peer_ramp, ext_sync, seen;
	logic [3:0]  grp_count_i, grp_pos_i, grp_count_o, grp_pos_o;
	logic [7:0]  blank_dly_i, tc_wdata_i, evb_alive_i, tc_rdata_o, tc_corr_o, peer_alive;
	logic [15:0] sw_period_i, meas_cur_i, evb_cur_i, evb_cur_o, min_pulse_o, peer_cur;
	logic [1:0]  sense_method_i, sense_method_o;
	int          err_count, checks_done, k, n;
	csg_phase_ctrl #(.SYNC_TO_CYCLES(TO_CYC), .REF_DLY_CYCLES(DLY_CYC)) csg_phase_ctrl_inst (.*);
	csg_peer_model csg_peer_model_inst (.sys_clk_i(sys_clk_i), .alive_i(peer_alive), .cur_i(peer_cur),
		.ramp_req_i(peer_ramp), .evb_alive_o(evb_alive_i), .evb_cur_o(evb_cur_i), .evb_ramp_o(evb_ramp_i));
	// Pin level: own driver when enabled, else the outside clock.
	assign sync_i = sync_oe_n_o ? ext_sync : sync_o;
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	// Internal clock toggles each cycle, the outside sync clock at half that.
	always @(negedge sys_clk_i) begin
		int_clk_i <= ~int_clk_i;
		if (int_clk_i) begin
			ext_sync <= ~ext_sync;
		end
	end
	task automatic cyc(input int c);
		repeat (c) @(negedge sys_clk_i);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Loads a three phase sharing setup at the given position.
	task automatic set_grp(input logic [3:0] pos);
		{grp_wr_i, grp_count_i, grp_pos_i, grp_share_en_i} = {1'b1, 4'h3, pos, 1'b1};
		cyc(1);
		grp_wr_i = 1'b0;
	endtask
	// Election, failover and trim steering.
	task automatic t_group();
		{peer_alive, meas_cur_i, peer_cur} = {8'h06, 16'h0100, 16'h0200};
		set_grp(4'h1);
		`CHK({grp_count_o, grp_pos_o, grp_share_en_o}, {4'h3, 4'h1, 1'b1})
		cyc(3);
		`CHK(is_ref_o, 1'b1)
		`CHK({evb_cur_vld_o, evb_cur_o}, {1'b1, 16'h0100})
		peer_alive = 8'h05;
		set_grp(4'h2);
		cyc(3);
		`CHK({is_ref_o, trim_zero_o, trim_up_o, trim_dn_o}, 4'b0010)
		meas_cur_i = 16'h0300;
		cyc(2);
		`CHK({trim_zero_o, trim_up_o, trim_dn_o}, 3'b001)
		peer_alive = 8'h04;
		cyc(3);
		`CHK(is_ref_o, 1'b1)
		fault_i = 1'b1;
		cyc(2);
		`CHK(is_ref_o, 1'b0)
		fault_i = 1'b0;
		cyc(2);
	endtask
	// Leader waits for firmware, delays, then releases the group.
	task automatic t_leader();
		{standby_monitor_i, ftr_wait_pg_i, enable_i} = 3'b111;
		cyc(8);
		`CHK(rail_en_o, 1'b0)
		fw_init_done_i = 1'b1;
		`WAITF(evb_ramp_o, 40)
		`CHK({pwm_go_o, k >= DLY_CYC - 1}, 2'b11)
		cyc(1);
		`CHK({rail_en_o, ftr_en_o}, 2'b10)
		power_good_i = 1'b1;
		cyc(2);
		`CHK(ftr_en_o, 1'b1)
		{power_good_i, ftr_wait_pg_i} = 2'b00;
		cyc(2);
		`CHK(ftr_en_o, 1'b1)
		enable_i = 1'b0;
		cyc(2);
		`CHK(rail_en_o, 1'b0)
	endtask
	// A member stays frozen until the peer ramp event arrives.
	task automatic t_member();
		peer_alive = 8'h01;
		cyc(3);
		enable_i = 1'b1;
		cyc(20);
		`CHK({rail_en_o, pwm_go_o, evb_ramp_o}, 3'b000)
		peer_ramp = 1'b1;
		cyc(1);
		peer_ramp = 1'b0;
		`WAITF(pwm_go_o, 4)
		cyc(1);
		`CHK(rail_en_o, 1'b1)
		{enable_i, fw_init_done_i} = 2'b00;
		cyc(2);
	endtask
	// Sync time-out, clock source modes and pin drivers.
	task automatic t_sync();
		{sync_to_en_i, enable_i} = 2'b11;
		cyc(2);
		enable_i = 1'b0;
		cyc(TO_CYC - 5);
		`CHK(sync_run_o, 1'b1)
		cyc(10);
		`CHK({sync_run_o, sync_oe_n_o}, 2'b01)
		{sync_pinstrap_i, sync_pin_out_i, sync_push_pull_i} = 3'b111;
		cyc(TO_CYC + 10);
		`CHK({sync_run_o, sync_oe_n_o}, 2'b10)
		sync_push_pull_i = 1'b0;
		cyc(3);
		seen = sync_oe_n_o;
		cyc(1);
		`CHK(timing_clk_o, int_clk_i)
		`CHK({sync_o, sync_oe_n_o}, {1'b0, ~seen})
		sync_pinstrap_i = 1'b0;
		cyc(3);
		`CHK(sync_oe_n_o, 1'b1)
		{sync_pin_out_i, sync_to_en_i} = 2'b00;
	endtask
	// Writes the correction setting and checks source and negated coefficient.
	task automatic tc_case(input logic [7:0] wd, input logic [8:0] exp);
		{tc_wr_i, tc_wdata_i} = {1'b1, wd};
		cyc(1);
		tc_wr_i = 1'b0;
		`CHK(tc_rdata_o, wd)
		cyc(2);
		`CHK({tc_src_ext_o, tc_corr_o}, exp)
	endtask
	// Minimum pulse, sense codes, mastering, blanking and temperature setting.
	task automatic t_misc();
		{min_duty_en_i, sw_period_i} = {1'b1, 16'h1F40};
		cyc(2);
		`CHK({min_duty_act_o, min_pulse_o}, {1'b1, 16'h003E})
		min_duty_en_i = 1'b0;
		cyc(2);
		`CHK(min_pulse_o, 16'h0000)
		for (k = 0; k < 4; k++) begin
			sense_method_i = 2'(k);
			cyc(2);
			`CHK(sense_method_o, (k == 3) ? 2'h0 : 2'(k))
		end
		tx_inhibit_i = 1'b1;
		cyc(2);
		`CHK(bus_master_ok_o, 1'b0)
		{tx_inhibit_i, blank_dly_i} = {1'b0, 8'h03};
		for (int e = 0; e < 2; e++) begin
			{top_edge_i, bot_edge_i} = (e == 0) ? 2'b10 : 2'b01;
			cyc(1);
			{top_edge_i, bot_edge_i, n} = 0;
			for (k = 0; k < 10; k++) begin
				n += blank_o;
				cyc(1);
			end
			`CHK(n, 3)
		end
		tc_case(8'h95, {1'b1, 8'hEB});
		tc_case(8'h2C, {1'b0, 8'hD4});
	endtask
	initial begin
		{srst_i, int_clk_i, ext_sync, peer_ramp, peer_alive, peer_cur} = {1'b1, 27'h0};
		{grp_wr_i, grp_count_i, grp_pos_i, grp_share_en_i, min_duty_en_i, sync_to_en_i} = '0;
		{sync_pinstrap_i, sync_pin_out_i, sync_push_pull_i, standby_monitor_i, tx_inhibit_i} = '0;
		{blank_dly_i, sense_method_i, ftr_wait_pg_i, tc_wr_i, tc_wdata_i, enable_i} = '0;
		{fw_init_done_i, power_good_i, fault_i, sw_period_i, top_edge_i, bot_edge_i, meas_cur_i} = '0;
		{err_count, checks_done} = 0;
		cyc(12);
		srst_i = 1'b0;
		cyc(1);
		`CHK({sync_oe_n_o, bus_master_ok_o, trim_zero_o, is_ref_o, tc_rdata_o}, 12'hE00)
		t_group();
		t_leader();
		t_member();
		t_sync();
		t_misc();
		stop_test();
	end
endmodule
`default_nettype wire
